// *** core/pspu_pkg.sv ***
package pspu_pkg;

  // Link phase codes, taken as {msg, cd, io}
  localparam logic [2:0] PH_DOUT = 3'h0;
  localparam logic [2:0] PH_DIN = 3'h1;
  localparam logic [2:0] PH_MOUT = 3'h6;
  localparam logic [2:0] PH_MIN = 3'h7;

  // How a transfer ended, reported to the user side
  localparam logic [2:0] END_NORMAL = 3'h0;
  localparam logic [2:0] END_LOGICAL = 3'h1;
  localparam logic [2:0] END_PHYSICAL = 3'h2;
  localparam logic [2:0] END_DISCONNECT = 3'h3;
  localparam logic [2:0] END_ATTENTION = 3'h4;

  // Status unit byte positions and flag bits
  localparam logic [15:0] SB_FLAGS = 16'h0002;
  localparam logic [15:0] SB_STATUS = 16'h0003;
  localparam logic [15:0] SB_SNS_FIRST = 16'h0004;
  localparam logic [15:0] SB_SNS_LSB = 16'h0007;
  localparam logic [15:0] SB_FAIL_LSB = 16'h000b;
  localparam int FLAG_SNS_BIT = 1;
  localparam int FLAG_FAIL_BIT = 0;
  localparam logic [7:0] SNS_MAX = 8'hfc;

  // Check word: four bytes, most significant first
  localparam logic [1:0] CRC_LAST_IDX = 2'h3;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED = 32'hffffffff;

  // Link engine states
  typedef enum logic [4:0] {
    LK_IDLE = 5'b00001,
    LK_PAY = 5'b00010,
    LK_PAD = 5'b00100,
    LK_CRC = 5'b01000,
    LK_BOUND = 5'b10000
  } pspu_link_t;

  // One byte through the check word, most significant bit first
  function automatic logic [31:0] pspu_crc_byte(input logic [31:0] crc,
                                                input logic [7:0] b);
    logic [31:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction : pspu_crc_byte

endpackage : pspu_pkg

// *** core/pspu_initiator.sv ***
// Function
// RULE1: Bus free or QAS after data: disconnect
// RULE2: Bus free or QAS after stream: disconnect
// RULE3: Payload then four check bytes, MSB first
// RULE4: Extra check word after every interval
// RULE5: Each stream unit carries header length bytes
// RULE6: Target ends stream on boundary, new header
// RULE7: Target ends write stream by phase change
// RULE8: Write: REQ after check word, send next
// RULE9: Target ends read stream via P_CRCA
// RULE10: Read: no P_CRCA, REQ means next unit
// RULE11: Read: P_CRCA seen, REQ means logical disconnect
// RULE12: Phase change: logical; free/msg-in: physical (code ends bus free or QAS with END_DISCONNECT, not END_PHYSICAL)
// RULE13: Attention stop keeps transferring until MESSAGE OUT
// RULE14: Offset need not drain between stream units
// RULE15: Status unit reports preceding header's task
// RULE16: Good, no flags: zero length, no unit
// RULE17: Status unit field layout
// RULE18: Check word covers preceding payload bytes
// RULE19: Even interval; zero or large: one word
// RULE20: Length excludes check and pad bytes
// RULE21: Sense flag clear: sense length zero
// RULE22: Sense length even, nonzero, at most 252
// RULE23: Receiver flags mismatching check word
module pspu_initiator
  import pspu_pkg::*;
#(
  parameter int LEN_W = 16
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // User command
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_write,
  input wire logic cmd_stream,
  input wire logic cmd_status,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [LEN_W-1:0] cmd_intv,
  input wire logic [7:0] cmd_seed,
  // User result
  output logic busy,
  output logic done,
  output logic [2:0] end_code,
  output logic crc_err,
  output logic [15:0] units,
  output logic [7:0] status,
  output logic sense_flag,
  output logic fail_flag,
  output logic [7:0] sense_len,
  output logic sense_bad,
  // Link
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_cd,
  input wire logic link_io,
  input wire logic link_msg,
  input wire logic link_crca,
  input wire logic link_free,
  input wire logic link_qas,
  input wire logic [7:0] link_din,
  output logic link_ack,
  output logic link_atn,
  output logic link_doe,
  output logic [7:0] link_dout
);

  // ---------------- user clock domain ----------------
  logic busy_reg, done_reg, go_tgl_reg, stop_tgl_reg;
  logic c_wr_reg, c_strm_reg, c_stat_reg;
  logic [LEN_W-1:0] c_len_reg, c_intv_reg;
  logic [7:0] c_seed_reg;
  logic fin_s1_reg, fin_s2_reg, fin_q_reg;
  logic [2:0] end_code_reg;
  logic crc_err_reg, sflag_reg, fflag_reg, sbad_reg;
  logic [15:0] units_reg;
  logic [7:0] status_reg, slen_reg;
  // Link domain state, declared early for the crossing
  logic fin_tgl_reg, l_crc_err_reg, l_sflag_reg, l_fflag_reg, l_slen_hi_reg;
  logic [2:0] l_code_reg;
  logic [15:0] l_units_reg;
  logic [7:0] l_status_reg, l_slen_reg;

  wire fin_evt = fin_s2_reg ^ fin_q_reg;
  wire start_ok = cmd_start && !busy_reg;
  wire l_sbad = l_sflag_reg && (l_slen_hi_reg || l_slen_reg == 8'h00 ||
                l_slen_reg[0] || l_slen_reg > SNS_MAX);

  // Command latch and start toggle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      go_tgl_reg <= 1'b0;
      stop_tgl_reg <= 1'b0;
    end else begin
      if (start_ok) begin
        busy_reg <= 1'b1;
        go_tgl_reg <= ~go_tgl_reg;
      end else if (fin_evt) begin
        busy_reg <= 1'b0;
      end
      if (cmd_stop && busy_reg) begin
        stop_tgl_reg <= ~stop_tgl_reg;
      end
    end
  end

  // Configuration, held steady while busy
  always_ff @(posedge clk) begin
    if (rst) begin
      c_wr_reg <= 1'b0;
      c_strm_reg <= 1'b0;
      c_stat_reg <= 1'b0;
      c_len_reg <= '0;
      c_intv_reg <= '0;
      c_seed_reg <= 8'h00;
    end else if (start_ok) begin
      c_wr_reg <= cmd_write;
      c_strm_reg <= cmd_stream;
      c_stat_reg <= cmd_status;
      c_len_reg <= cmd_len;
      c_intv_reg <= cmd_intv;
      c_seed_reg <= cmd_seed;
    end
  end

  // Completion toggle synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      fin_s1_reg <= 1'b0;
      fin_s2_reg <= 1'b0;
      fin_q_reg <= 1'b0;
    end else begin
      fin_s1_reg <= fin_tgl_reg;
      fin_s2_reg <= fin_s1_reg;
      fin_q_reg <= fin_s2_reg;
    end
  end

  // Result capture; link results are stable once the toggle moved
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
      end_code_reg <= END_NORMAL;
      crc_err_reg <= 1'b0;
      units_reg <= 16'h0000;
      status_reg <= 8'h00;
      sflag_reg <= 1'b0;
      fflag_reg <= 1'b0;
      slen_reg <= 8'h00;
      sbad_reg <= 1'b0;
    end else begin
      done_reg <= fin_evt;
      if (fin_evt) begin
        end_code_reg <= l_code_reg;
        crc_err_reg <= l_crc_err_reg;
        units_reg <= l_units_reg;
        status_reg <= l_status_reg;
        sflag_reg <= l_sflag_reg;
        fflag_reg <= l_fflag_reg;
        slen_reg <= l_sflag_reg ? l_slen_reg : 8'h00; // RULE21
        sbad_reg <= l_sbad; // RULE22
      end
    end
  end

  sense_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE21
    done_reg && !sflag_reg |-> slen_reg == 8'h00)
    else $error("sense length reported without sense flag");

  // ---------------- link clock domain ----------------
  logic lrst_s1_reg, lrst_s2_reg;
  logic go_s1_reg, go_s2_reg, go_q_reg, st_s1_reg, st_s2_reg, st_q_reg;
  logic req_q_reg, ack_reg, atn_reg, doe_reg, crca_seen_reg;
  logic [7:0] dout_reg;
  pspu_link_t st_reg;
  logic [2:0] phase_ref_reg;
  logic [LEN_W-1:0] remain_reg, seg_left_reg;
  logic [15:0] byte_idx_reg;
  logic [1:0] segb_reg, pad_left_reg, crc_cnt_reg;
  logic [31:0] crc_reg, crc_sh_reg;

  wire lrst = lrst_s2_reg;
  wire go_evt = go_s2_reg ^ go_q_reg;
  wire stop_evt = st_s2_reg ^ st_q_reg;
  wire req_edge = link_req ^ req_q_reg;
  wire [2:0] phase = {link_msg, link_cd, link_io};
  wire ph_chg = phase != phase_ref_reg;
  wire freed = link_free || link_qas;
  // Interval only counts when nonzero and under the length
  wire intv_on = c_intv_reg != '0 && c_intv_reg < c_len_reg; // RULE19
  wire [LEN_W-1:0] seg_first = intv_on ? c_intv_reg : c_len_reg; // RULE4
  wire [LEN_W-1:0] seg_next = (intv_on && remain_reg > c_intv_reg) ?
                              c_intv_reg : remain_reg;
  wire read_end = crca_seen_reg && !c_wr_reg;
  wire in_bound = st_reg == LK_BOUND;
  wire cont = in_bound && req_edge && c_strm_reg && !read_end &&
              !freed && !ph_chg; // RULE8 RULE10 RULE14
  wire take_pay = (req_edge && st_reg == LK_PAY) || cont;
  wire take_pad = req_edge && st_reg == LK_PAD;
  wire take_crc = req_edge && st_reg == LK_CRC;
  wire [7:0] tx_pay = c_seed_reg + byte_idx_reg[7:0];
  wire [7:0] pay_byte = c_wr_reg ? tx_pay : link_din;
  wire [7:0] pad_byte = c_wr_reg ? 8'h00 : link_din;
  wire [31:0] crc_pay = pspu_crc_byte(crc_reg, pay_byte); // RULE18
  wire [31:0] crc_pad = pspu_crc_byte(crc_reg, pad_byte);
  wire [1:0] segb_n = segb_reg + 2'h1;
  wire [1:0] pad_n = 2'(~segb_n + 2'h1); // RULE20
  wire atn_done = atn_reg && phase == PH_MOUT; // RULE13
  // Finish decisions in priority order
  wire fin_free = in_bound && freed; // RULE1 RULE2
  wire fin_phase = in_bound && !freed && ph_chg; // RULE7 RULE12
  wire fin_crca = in_bound && req_edge && c_strm_reg && read_end &&
                  !freed && !ph_chg; // RULE9 RULE11
  wire fin_now = st_reg != LK_IDLE &&
                 (atn_done || fin_free || fin_phase || fin_crca);
  wire [2:0] ph_code = !c_strm_reg ? END_NORMAL :
                       (phase == PH_MIN) ? END_PHYSICAL : END_LOGICAL;
  wire [2:0] fin_code = atn_done ? END_ATTENTION :
                        fin_free ? END_DISCONNECT :
                        fin_phase ? ph_code : END_LOGICAL;
  wire empty_stat = c_stat_reg && c_len_reg == '0; // RULE16

  // Reset and command synchronisers
  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= rst;
    lrst_s2_reg <= lrst_s1_reg;
    go_s1_reg <= go_tgl_reg;
    go_s2_reg <= go_s1_reg;
    st_s1_reg <= stop_tgl_reg;
    st_s2_reg <= st_s1_reg;
  end

  // Edge memories
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      go_q_reg <= 1'b0;
      st_q_reg <= 1'b0;
      req_q_reg <= 1'b0;
    end else begin
      go_q_reg <= go_s2_reg;
      st_q_reg <= st_s2_reg;
      req_q_reg <= link_req;
    end
  end

  // Link engine: framing, pads, check words and endings
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      st_reg <= LK_IDLE;
      {ack_reg, atn_reg, doe_reg, crca_seen_reg, fin_tgl_reg} <= 5'h00;
      {l_crc_err_reg, l_sflag_reg, l_fflag_reg, l_slen_hi_reg} <= 4'h0;
      dout_reg <= 8'h00;
      phase_ref_reg <= PH_DOUT;
      remain_reg <= '0;
      seg_left_reg <= '0;
      byte_idx_reg <= 16'h0000;
      {segb_reg, pad_left_reg, crc_cnt_reg} <= 6'h00;
      crc_reg <= CRC_SEED;
      crc_sh_reg <= CRC_SEED;
      l_code_reg <= END_NORMAL;
      l_units_reg <= 16'h0000;
      l_status_reg <= 8'h00;
      l_slen_reg <= 8'h00;
    end else if (st_reg == LK_IDLE) begin
      if (go_evt) begin
        phase_ref_reg <= phase;
        {l_crc_err_reg, l_sflag_reg, l_fflag_reg, l_slen_hi_reg} <= 4'h0;
        l_status_reg <= 8'h00;
        l_slen_reg <= 8'h00;
        l_units_reg <= 16'h0000;
        remain_reg <= c_len_reg;
        seg_left_reg <= seg_first;
        segb_reg <= 2'h0;
        byte_idx_reg <= 16'h0000;
        crc_reg <= CRC_SEED;
        crca_seen_reg <= 1'b0;
        if (empty_stat) begin
          l_code_reg <= END_NORMAL; // RULE16
          fin_tgl_reg <= ~fin_tgl_reg;
        end else begin
          st_reg <= LK_PAY;
          doe_reg <= c_wr_reg;
        end
      end
    end else if (fin_now) begin
      st_reg <= LK_IDLE;
      l_code_reg <= fin_code;
      fin_tgl_reg <= ~fin_tgl_reg;
      doe_reg <= 1'b0;
      atn_reg <= 1'b0;
      dout_reg <= 8'h00;
    end else begin
      if (stop_evt) begin
        atn_reg <= 1'b1; // RULE13
      end
      if (cont) begin
        crca_seen_reg <= 1'b0;
      end
      if (!c_wr_reg && link_crca && !in_bound) begin
        crca_seen_reg <= 1'b1; // RULE11
      end
      if (take_pay) begin
        st_reg <= LK_PAY;
        ack_reg <= ~ack_reg;
        dout_reg <= c_wr_reg ? tx_pay : 8'h00;
        crc_reg <= crc_pay;
        byte_idx_reg <= byte_idx_reg + 16'h0001;
        remain_reg <= remain_reg - LEN_W'(1); // RULE5
        seg_left_reg <= seg_left_reg - LEN_W'(1);
        segb_reg <= segb_n;
        if (c_stat_reg && !c_wr_reg) begin // RULE17
          if (byte_idx_reg == SB_FLAGS) begin
            l_sflag_reg <= link_din[FLAG_SNS_BIT];
            l_fflag_reg <= link_din[FLAG_FAIL_BIT];
          end else if (byte_idx_reg == SB_STATUS) begin
            l_status_reg <= link_din; // RULE15
          end else if (byte_idx_reg >= SB_SNS_FIRST &&
                       byte_idx_reg < SB_SNS_LSB && link_din != 8'h00) begin
            l_slen_hi_reg <= 1'b1;
          end else if (byte_idx_reg == SB_SNS_LSB) begin
            l_slen_reg <= link_din;
          end
        end
        if (seg_left_reg == LEN_W'(1)) begin
          if (pad_n != 2'h0) begin
            st_reg <= LK_PAD;
            pad_left_reg <= pad_n;
          end else begin
            st_reg <= LK_CRC;
            crc_sh_reg <= crc_pay;
            crc_cnt_reg <= 2'h0;
          end
        end
      end else if (take_pad) begin
        ack_reg <= ~ack_reg;
        dout_reg <= 8'h00;
        crc_reg <= crc_pad;
        pad_left_reg <= pad_left_reg - 2'h1;
        segb_reg <= segb_reg + 2'h1;
        if (pad_left_reg == 2'h1) begin
          st_reg <= LK_CRC;
          crc_sh_reg <= crc_pad;
          crc_cnt_reg <= 2'h0;
        end
      end else if (take_crc) begin
        ack_reg <= ~ack_reg;
        dout_reg <= c_wr_reg ? crc_sh_reg[31:24] : 8'h00; // RULE3
        if (!c_wr_reg && link_din != crc_sh_reg[31:24]) begin
          l_crc_err_reg <= 1'b1; // RULE23
        end
        crc_sh_reg <= {crc_sh_reg[23:0], 8'h00};
        crc_cnt_reg <= crc_cnt_reg + 2'h1;
        segb_reg <= 2'h0;
        crc_reg <= CRC_SEED;
        if (crc_cnt_reg == CRC_LAST_IDX) begin
          if (remain_reg == '0) begin
            st_reg <= LK_BOUND;
            l_units_reg <= l_units_reg + 16'h0001;
            remain_reg <= c_len_reg;
            seg_left_reg <= seg_first;
            byte_idx_reg <= 16'h0000;
          end else begin
            st_reg <= LK_PAY;
            seg_left_reg <= seg_next;
          end
        end
      end
    end
  end

  // Pins driven straight from flops
  assign link_ack = ack_reg;
  assign link_atn = atn_reg;
  assign link_doe = doe_reg;
  assign link_dout = dout_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign end_code = end_code_reg;
  assign crc_err = crc_err_reg;
  assign units = units_reg;
  assign status = status_reg;
  assign sense_flag = sflag_reg;
  assign fail_flag = fflag_reg;
  assign sense_len = slen_reg;
  assign sense_bad = sbad_reg;

  crc_msb_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE3
    take_crc && c_wr_reg && !fin_now |=>
      link_dout == $past(crc_sh_reg[31:24]))
    else $error("check byte not sent most significant first");
  pad_align_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE20
    st_reg == LK_CRC && crc_cnt_reg == 2'h0 |-> segb_reg == 2'h0)
    else $error("check word not on a four byte boundary");
  intv_seg_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE4
    st_reg == LK_PAY && intv_on |-> seg_left_reg <= c_intv_reg)
    else $error("segment longer than check interval");
  unit_len_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE5
    st_reg == LK_PAY |-> remain_reg <= c_len_reg && remain_reg != '0)
    else $error("unit byte count out of range");
  atn_hold_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE13
    atn_reg && in_bound == 1'b0 && phase != PH_MOUT &&
      st_reg != LK_IDLE |=> st_reg != LK_IDLE)
    else $error("transfer abandoned before MESSAGE OUT");
  crca_end_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE11
    fin_crca && !atn_done |=> st_reg == LK_IDLE && l_code_reg == END_LOGICAL)
    else $error("read stream did not end after P_CRCA");
  free_disc_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE1
    in_bound && freed && !atn_done |=> l_code_reg == END_DISCONNECT)
    else $error("bus free not treated as disconnect");
  phase_end_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE12
    fin_phase && !atn_done && c_strm_reg |=> st_reg == LK_IDLE &&
      (l_code_reg == END_LOGICAL || l_code_reg == END_PHYSICAL))
    else $error("phase change did not end the stream");
  next_unit_a: assert property (@(posedge link_clk) disable iff (lrst) // RULE8
    cont && !atn_done |=> ##[0:1] st_reg != LK_IDLE && link_ack != $past(ack_reg))
    else $error("next stream unit not started");

endmodule : pspu_initiator

// *** sim/pspu_target_model.sv ***
module pspu_target_model
  import pspu_pkg::*;
(
  // Link clock
  input wire logic link_clk,
  // Target side of the link
  output logic link_req,
  output logic link_cd,
  output logic link_io,
  output logic link_msg,
  output logic link_crca,
  output logic link_free,
  output logic link_qas,
  output logic [7:0] link_din,
  // Initiator side of the link
  input wire logic link_ack,
  input wire logic link_atn,
  input wire logic link_doe,
  input wire logic [7:0] link_dout
);
  timeunit 1ns;
  timeprecision 1ps;

  int bad = 0;
  logic [31:0] crc;

  // Idle link: data in phase, no strobe
  initial begin
    {link_req, link_crca, link_free, link_qas} = 4'h0;
    {link_msg, link_cd, link_io} = PH_DIN;
    link_din = 8'h5a;
  end

  // Check word step, MSB first, no final inversion
  function automatic logic [31:0] step(input logic [31:0] c,
                                       input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction : step

  // New phase at a link edge
  task automatic set_phase(input logic [2:0] ph);
    @(posedge link_clk);
    {link_msg, link_cd, link_io} <= ph;
  endtask : set_phase

  // One REQ edge, byte held until ACK toggles
  task automatic put(input logic [7:0] d, input logic wr);
    logic a;
    a = link_ack;
    @(posedge link_clk);
    link_din <= d;
    link_req <= ~link_req;
    for (int i = 0; i < 6 && link_ack === a; i++) begin
      @(negedge link_clk);
    end
    if (link_ack === a) bad++;
    if (link_doe !== wr || (wr && link_dout !== d)) bad++;
    @(posedge link_clk);
    link_din <= ~d; // Released: stale value hidden
  endtask : put

  // Whole unit: payload, pad, check word per segment; e flips check
  task automatic unit(input int len, input int intv, input logic [7:0] base,
                      input logic [95:0] st, input logic wr, input logic e);
    int seg;
    logic [7:0] d;
    seg = 0;
    crc = CRC_SEED;
    for (int k = 0; k < len; k++) begin
      d = (st != 0) ? st[8*(11-k) +: 8] : base + k[7:0];
      put(d, wr);
      crc = step(crc, d);
      seg++;
      if (seg == intv || k == len - 1) begin
        while (seg % 4 != 0) begin
          put(8'h00, wr);
          crc = step(crc, 8'h00);
          seg++;
        end
        for (int j = 3; j >= 0; j--) begin
          put(crc[8*j +: 8] ^ {7'h0, e}, wr);
        end
        seg = 0;
        crc = CRC_SEED;
      end
    end
  endtask : unit

  // Close at a unit boundary: phase, bus free, QAS or REQ edge
  task automatic finish(input int how, input logic [2:0] ph);
    @(posedge link_clk);
    case (how)
      1: link_free <= 1'b1;
      2: link_qas <= 1'b1;
      3: link_req <= ~link_req;
      default: {link_msg, link_cd, link_io} <= ph;
    endcase
    repeat (12) @(posedge link_clk);
    {link_crca, link_free, link_qas} <= 3'h0;
  endtask : finish

  // P_CRCA raised before the closing boundary
  task automatic crca_on();
    @(posedge link_clk);
    link_crca <= 1'b1;
  endtask : crca_on

  // Attention answered only at a boundary
  task automatic atn_end();
    if (link_atn !== 1'b1) bad++;
    finish(0, PH_MOUT);
  endtask : atn_end

endmodule : pspu_target_model

// *** sim/testbench.sv ***
module testbench
  import pspu_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_stop = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_stream = 1'b0;
  logic cmd_status = 1'b0;
  logic [15:0] cmd_len = 16'h0;
  logic [15:0] cmd_intv = 16'h0;
  logic [7:0] cmd_seed = 8'h0;
  logic busy, done, crc_err, sense_flag, fail_flag, sense_bad;
  logic [2:0] end_code, code;
  logic [15:0] units;
  logic [7:0] status, sense_len, link_din, link_dout, b, sl;
  logic link_req, link_cd, link_io, link_msg, link_crca, link_free;
  logic link_qas, link_ack, link_atn, link_doe;
  logic [1:0] fl;
  logic [95:0] st;
  logic [38:0] res;
  logic [38:0] expq[$];
  int num_errors = 0;
  int checked = 0;
  int seed = 93031;

  // Clocks, link clock with its own phase
  always #20 clk = ~clk;
  initial begin
    #3.1;
    forever #62.5 link_clk = ~link_clk;
  end

  pspu_initiator #(.LEN_W(16)) pspu_initiator_inst (
    .clk, .rst, .cmd_start, .cmd_stop, .cmd_write, .cmd_stream, .cmd_status,
    .cmd_len, .cmd_intv, .cmd_seed, .busy, .done, .end_code, .crc_err,
    .units, .status, .sense_flag, .fail_flag, .sense_len, .sense_bad,
    .link_clk, .link_req, .link_cd, .link_io, .link_msg, .link_crca,
    .link_free, .link_qas, .link_din, .link_ack, .link_atn, .link_doe,
    .link_dout
  );

  pspu_target_model pspu_target_model_inst (
    .link_clk, .link_req, .link_cd, .link_io, .link_msg, .link_crca,
    .link_free, .link_qas, .link_din, .link_ack, .link_atn, .link_doe,
    .link_dout
  );

  // Result word as compared
  assign res = {end_code, crc_err, units, status, sense_flag, fail_flag,
                sense_len, sense_bad};

  task automatic check_res(input logic [38:0] exp, input logic [38:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: result %h expected %h", $time, got, exp);
    end
  endtask : check_res

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // Compare each finished transfer with the oldest note
  always @(negedge clk) begin
    if (done === 1'b1) begin
      check_res(expq.size() > 0 ? expq.pop_front() : 39'h0, res);
    end
  end

  function automatic logic [38:0] ex(input logic [2:0] c, input logic e,
                                     input logic [15:0] u,
                                     input logic [18:0] s);
    return {c, e, u, s};
  endfunction : ex

  // Start one transfer and note its expected result
  task automatic go(input logic [2:0] m, input logic [15:0] len,
                    input logic [15:0] intv, input logic [2:0] ph,
                    input logic [38:0] e);
    pspu_target_model_inst.set_phase(ph);
    @(negedge clk);
    {cmd_write, cmd_stream, cmd_status} = m;
    cmd_len = len;
    cmd_intv = intv;
    cmd_start = 1'b1;
    expq.push_back(e);
    @(negedge clk);
    cmd_start = 1'b0;
    repeat (5) @(posedge link_clk);
  endtask : go

  // Bounded wait for the end of a transfer
  task automatic fin(input string name);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    check_val({31'h0, busy}, 32'h0);
    @(negedge clk);
    $display("Test %s done", name);
  endtask : fin

  task automatic results();
    $display("Compares %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(posedge link_clk);
    @(negedge clk);
    b = 8'($random(seed));
    go(3'b000, 16'h6, 16'h0, PH_DIN, ex(END_NORMAL, 0, 16'h1, 19'h0));
    pspu_target_model_inst.unit(6, 0, b, 96'h0, 0, 0);
    pspu_target_model_inst.finish(0, PH_MIN);
    fin("read");
    go(3'b000, 16'ha, 16'h4, PH_DIN, ex(END_DISCONNECT, 0, 16'h1, 19'h0));
    pspu_target_model_inst.unit(10, 4, b, 96'h0, 0, 0);
    pspu_target_model_inst.finish(1, 3'h0);
    fin("interval");
    go(3'b000, 16'h8, 16'h8, PH_DIN, ex(END_NORMAL, 1, 16'h1, 19'h0));
    pspu_target_model_inst.unit(8, 8, b, 96'h0, 0, 1);
    pspu_target_model_inst.finish(0, PH_MIN);
    fin("crc error");
    // Stream ends: bus free, QAS, message in, other phase
    for (int i = 1; i < 5; i++) begin
      b = 8'($random(seed));
      code = (i == 3) ? END_PHYSICAL : (i == 4) ? END_LOGICAL : END_DISCONNECT;
      go(3'b010, 16'h4, 16'h2, PH_DIN, ex(code, 0, 16'h2, 19'h0));
      repeat (2) pspu_target_model_inst.unit(4, 2, b, 96'h0, 0, 0);
      pspu_target_model_inst.finish(i < 3 ? i : 0, i == 3 ? PH_MIN : PH_DOUT);
      fin("stream end");
    end
    go(3'b010, 16'h4, 16'h0, PH_DIN, ex(END_LOGICAL, 0, 16'h3, 19'h0));
    repeat (2) pspu_target_model_inst.unit(4, 0, b, 96'h0, 0, 0);
    pspu_target_model_inst.crca_on();
    pspu_target_model_inst.unit(4, 0, b, 96'h0, 0, 0);
    pspu_target_model_inst.finish(3, 3'h0);
    fin("crca");
    cmd_seed = 8'($random(seed));
    go(3'b110, 16'h6, 16'h0, PH_DOUT, ex(END_PHYSICAL, 0, 16'h2, 19'h0));
    repeat (2) pspu_target_model_inst.unit(6, 0, cmd_seed, 96'h0, 1, 0);
    pspu_target_model_inst.finish(0, PH_MIN);
    fin("write");
    go(3'b110, 16'h6, 16'h0, PH_DOUT, ex(END_ATTENTION, 0, 16'h1, 19'h0));
    @(negedge clk);
    cmd_stop = 1'b1;
    @(negedge clk);
    cmd_stop = 1'b0;
    pspu_target_model_inst.unit(6, 0, cmd_seed, 96'h0, 1, 0);
    pspu_target_model_inst.atn_end();
    fin("attention");
    check_val(pspu_target_model_inst.bad, 32'h0);
    check_val({31'h0, link_atn}, 32'h0);
    // Status units: valid, too long, odd, sense flag clear
    for (int i = 0; i < 4; i++) begin
      sl = (i == 1) ? 8'hfe : (i > 1) ? 8'h03 : SNS_MAX;
      fl = (i == 3) ? 2'b01 : 2'b10;
      st = {16'h0, 6'h0, fl, 8'h02, 24'h0, sl, 32'h4};
      go(3'b001, 16'hc, 16'h0, PH_DIN, ex(END_NORMAL, 0, 16'h1,
         {8'h02, fl, fl[1] ? sl : 8'h0, i == 1 || i == 2}));
      pspu_target_model_inst.unit(12, 0, 8'h0, st, 0, 0);
      pspu_target_model_inst.finish(0, PH_MIN);
      fin("status");
    end
    go(3'b001, 16'h0, 16'h0, PH_DIN, ex(END_NORMAL, 0, 16'h0, 19'h0));
    fin("no status");
    check_val(pspu_target_model_inst.bad, 32'h0);
    results();
  end

endmodule : testbench
